// >>> src/srmi_cfg.svh
// timing and address constants of the shared rom/ram memory interface
`ifndef SRMI_CFG_SVH
`define SRMI_CFG_SVH

`define SRMI_ADDR_W 19
`define SRMI_DATA_W 16
`define SRMI_CNT_W 3

`define SRMI_XTAL_KHZ 9600
`define SRMI_CORE_KHZ 38400
`define SRMI_CLK_NS 20

// least times, rounded up to whole cycles
`define SRMI_T_RC_NS 130
`define SRMI_T_CSOE_NS 45
`define SRMI_T_CSWE_NS 40
`define SRMI_ACC_CYC ((`SRMI_T_RC_NS + `SRMI_CLK_NS - 1) / `SRMI_CLK_NS)
`define SRMI_OE_CYC ((`SRMI_T_CSOE_NS + `SRMI_CLK_NS - 1) / `SRMI_CLK_NS)
`define SRMI_WE_CYC ((`SRMI_T_CSWE_NS + `SRMI_CLK_NS - 1) / `SRMI_CLK_NS)

// byte-wide ram phases, counted from the select edge
`define SRMI_NR_LO_CYC 3
`define SRMI_NR_RBS_CYC 4
`define SRMI_NW_LO_WE_CYC 1
`define SRMI_NW_RBS_CYC 3
`define SRMI_NW_HI_WE_CYC 5

`define SRMI_BOOT_ADDR 19'h00100

`endif

// >>> src/srmi_pkg.sv
// types of the shared rom/ram memory interface
`include "srmi_cfg.svh"
package srmi_pkg;
  typedef logic [`SRMI_CNT_W-1:0] srmi_cnt_t;
  typedef logic [`SRMI_ADDR_W-1:0] srmi_addr_t;
  typedef logic [`SRMI_DATA_W-1:0] srmi_data_t;
  typedef struct packed {
    logic write;
    logic ram;
    srmi_addr_t addr;
    srmi_data_t wdata;
  } srmi_req_t;
  typedef enum logic [1:0] {OWN_DSP, OWN_CPU, OWN_BOOT} srmi_owner_t;
  typedef enum logic {ST_IDLE, ST_ACCESS} srmi_state_t;
endpackage

// >>> src/srmi_arb.sv
// round-robin arbiter between the two processors
`timescale 1ns/1ps
`default_nettype none
module srmi_arb (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] req_i,
  output logic [1:0] gnt_o
);
  logic last_q;

  // the side that did not win last time has priority on a tie
  always_comb begin
    gnt_o = 2'h0;
    if (req_i == 2'h3) begin
      gnt_o = last_q ? 2'h1 : 2'h2;
    end else begin
      gnt_o = req_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      last_q <= 1'b1;
    end else if (|gnt_o) begin
      last_q <= gnt_o[1];
    end
  end
endmodule
`default_nettype wire

// >>> src/srmi_top.sv
// shared rom/ram external memory sequencer with boot fetch and power-down
`timescale 1ns/1ps
`default_nettype none
`include "srmi_cfg.svh"
module srmi_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic POWER_DOWN_N_I,
  input wire logic RAM_WIDE_I,
  input wire logic SYNTH_RUN_I,
  input wire logic DSP_REQ_VALID_I,
  input wire srmi_pkg::srmi_req_t DSP_REQ_I,
  output logic DSP_REQ_READY_O,
  output logic DSP_RSP_VALID_O,
  input wire logic CPU_REQ_VALID_I,
  input wire srmi_pkg::srmi_req_t CPU_REQ_I,
  output logic CPU_REQ_READY_O,
  output logic CPU_RSP_VALID_O,
  output srmi_pkg::srmi_data_t RSP_DATA_O,
  output srmi_pkg::srmi_addr_t MEM_ADDR_O,
  input wire srmi_pkg::srmi_data_t MEM_DATA_I,
  output srmi_pkg::srmi_data_t MEM_DATA_O,
  output logic MEM_DATA_OE_O,
  output logic PIN_OE_O,
  output logic ROM_SELECT_N_O,
  output logic RAM_SELECT_N_O,
  output logic MEM_READ_ENABLE_N_O,
  output logic RAM_WRITE_N_O,
  output logic RAM_BYTE_SEL_O,
  output logic RUN_O,
  output logic OSC_ENABLE_O
);
  import srmi_pkg::*;

  localparam srmi_cnt_t ACC_LAST = srmi_cnt_t'(`SRMI_ACC_CYC - 1);
  localparam srmi_cnt_t OE_CYC = srmi_cnt_t'(`SRMI_OE_CYC);
  localparam srmi_cnt_t WE_CYC = srmi_cnt_t'(`SRMI_WE_CYC);
  localparam srmi_cnt_t NR_LO = srmi_cnt_t'(`SRMI_NR_LO_CYC);
  localparam srmi_cnt_t NR_RBS = srmi_cnt_t'(`SRMI_NR_RBS_CYC);
  localparam srmi_cnt_t NW_LO_WE = srmi_cnt_t'(`SRMI_NW_LO_WE_CYC);
  localparam srmi_cnt_t NW_RBS = srmi_cnt_t'(`SRMI_NW_RBS_CYC);
  localparam srmi_cnt_t NW_HI_WE = srmi_cnt_t'(`SRMI_NW_HI_WE_CYC);

  srmi_state_t state_q;
  srmi_cnt_t cnt_q;
  srmi_cnt_t cnt_n;
  srmi_owner_t owner_q;
  srmi_owner_t owner_d;
  srmi_req_t req_q;
  srmi_req_t acc_d;
  srmi_req_t cur;
  srmi_addr_t addr_q;
  srmi_data_t dout_q;
  srmi_data_t dout_d;
  srmi_data_t rdata_q;
  logic [1:0] gnt;
  logic boot_pend_q;
  logic pd_q;
  logic run_q;
  logic start;
  logic last;
  logic act_n;
  logic narrow;
  logic rom_cs_n_q;
  logic ram_cs_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic rbs_q;
  logic dout_en_q;
  logic rom_cs_n_d;
  logic ram_cs_n_d;
  logic oe_n_d;
  logic we_n_d;
  logic rbs_d;
  logic dout_en_d;
  logic rsp_dsp_q;
  logic rsp_cpu_q;

  // processors compete only once the boot fetch has gone out
  srmi_arb u_arb (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .req_i({CPU_REQ_VALID_I, DSP_REQ_VALID_I}
           & {2{state_q == ST_IDLE && !boot_pend_q && !pd_q}}),
    .gnt_o(gnt)
  );

  assign DSP_REQ_READY_O = gnt[0];
  assign CPU_REQ_READY_O = gnt[1];
  assign start = state_q == ST_IDLE && !pd_q && (boot_pend_q || |gnt);
  assign last = state_q == ST_ACCESS && cnt_q == ACC_LAST;
  assign narrow = !RAM_WIDE_I;

  always_comb begin
    owner_d = OWN_BOOT;
    acc_d = '0;
    acc_d.addr = `SRMI_BOOT_ADDR;
    if (!boot_pend_q) begin
      owner_d = gnt[1] ? OWN_CPU : OWN_DSP;
      acc_d = gnt[1] ? CPU_REQ_I : DSP_REQ_I;
      // the rom is never written: a rom write runs as a read
      acc_d.write = acc_d.write & acc_d.ram;
    end
  end

  // reset arrives already cleaned by the schmitt pad stage
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else if (pd_q) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else if (start) begin
      state_q <= ST_ACCESS;
      cnt_q <= '0;
    end else if (last) begin
      state_q <= ST_IDLE;
    end else if (state_q == ST_ACCESS) begin
      cnt_q <= cnt_q + srmi_cnt_t'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      req_q <= '0;
      owner_q <= OWN_BOOT;
      boot_pend_q <= 1'b1;
    end else if (start) begin
      req_q <= acc_d;
      owner_q <= owner_d;
      boot_pend_q <= 1'b0;
    end
  end

  // strobes are computed for the coming cycle and registered
  always_comb begin
    cur = start ? acc_d : req_q;
    act_n = start || (state_q == ST_ACCESS && !last && !pd_q);
    cnt_n = start ? '0 : cnt_q + srmi_cnt_t'(1);
    rom_cs_n_d = !(act_n && !cur.ram);
    ram_cs_n_d = !(act_n && cur.ram);
    oe_n_d = !(act_n && !cur.write && cnt_n >= OE_CYC);
    rbs_d = act_n && cur.ram && narrow
            && cnt_n >= (cur.write ? NW_RBS : NR_RBS);
    if (narrow) begin
      we_n_d = !(act_n && cur.write
                 && (cnt_n == NW_LO_WE || cnt_n == NW_HI_WE));
    end else begin
      we_n_d = !(act_n && cur.write && cnt_n >= WE_CYC
                 && cnt_n < ACC_LAST);
    end
    dout_en_d = act_n && cur.write;
    dout_d = cur.wdata;
    if (narrow && cnt_n >= NW_RBS) begin
      dout_d = {cur.wdata[15:8], cur.wdata[15:8]};
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rom_cs_n_q <= 1'b1;
      ram_cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rbs_q <= 1'b0;
      dout_en_q <= 1'b0;
    end else begin
      rom_cs_n_q <= rom_cs_n_d;
      ram_cs_n_q <= ram_cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      rbs_q <= rbs_d;
      dout_en_q <= dout_en_d;
    end
  end

  // address and write data hold between accesses to spare pin toggles
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      addr_q <= '0;
      dout_q <= '0;
    end else begin
      if (start) begin
        addr_q <= acc_d.addr;
      end
      if (dout_en_d) begin
        dout_q <= dout_d;
      end
    end
  end

  // byte ram: low byte sampled before byte select rises, high at end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rdata_q <= '0;
    end else if (state_q == ST_ACCESS && !req_q.write && !pd_q) begin
      if (narrow && req_q.ram && cnt_q == NR_LO) begin
        rdata_q[7:0] <= MEM_DATA_I[7:0];
      end else if (last) begin
        if (narrow && req_q.ram) begin
          rdata_q[15:8] <= MEM_DATA_I[7:0];
        end else begin
          rdata_q <= MEM_DATA_I;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rsp_dsp_q <= 1'b0;
      rsp_cpu_q <= 1'b0;
    end else begin
      rsp_dsp_q <= last && !pd_q && owner_q == OWN_DSP;
      rsp_cpu_q <= last && !pd_q && owner_q != OWN_DSP;
    end
  end

  // power-down sticks until the next reset; releasing the pin alone
  // does not wake the part
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      pd_q <= 1'b0;
    end else if (!POWER_DOWN_N_I) begin
      pd_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      run_q <= 1'b0;
    end else begin
      run_q <= SYNTH_RUN_I && !boot_pend_q && !pd_q;
    end
  end

  assign MEM_ADDR_O = addr_q;
  assign MEM_DATA_O = dout_q;
  assign MEM_DATA_OE_O = dout_en_q && !pd_q;
  assign PIN_OE_O = !pd_q;
  assign OSC_ENABLE_O = !pd_q;
  assign ROM_SELECT_N_O = rom_cs_n_q;
  assign RAM_SELECT_N_O = ram_cs_n_q;
  assign MEM_READ_ENABLE_N_O = oe_n_q;
  assign RAM_WRITE_N_O = we_n_q;
  assign RAM_BYTE_SEL_O = rbs_q;
  assign RUN_O = run_q;
  assign RSP_DATA_O = rdata_q;
  assign DSP_RSP_VALID_O = rsp_dsp_q;
  assign CPU_RSP_VALID_O = rsp_cpu_q;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  sel_excl_a: assert property (!(!rom_cs_n_q && !ram_cs_n_q))
    else $error("rom and ram selected together");
  write_ram_a: assert property (!we_n_q |-> !ram_cs_n_q && oe_n_q)
    else $error("write strobe outside a ram access");
  data_drive_a: assert property (MEM_DATA_OE_O |-> !ram_cs_n_q)
    else $error("data bus driven outside a ram write");
  pd_float_a: assert property (!POWER_DOWN_N_I |=> !PIN_OE_O
    && !MEM_DATA_OE_O && !OSC_ENABLE_O)
    else $error("pins not floated in power-down");
  pd_sticky_a: assert property (!PIN_OE_O |=> !PIN_OE_O)
    else $error("left power-down without reset");
  boot_fetch_a: assert property ($fell(boot_pend_q) |->
    !ROM_SELECT_N_O && MEM_ADDR_O == `SRMI_BOOT_ADDR && !boot_pend_q)
    else $error("boot fetch not at rom word 0100h");
  run_low_a: assert property (boot_pend_q |=> !RUN_O)
    else $error("run indicator high before boot fetch");
  acc_len_a: assert property (start |=>
    (!rom_cs_n_q || !ram_cs_n_q || pd_q)[*7] ##1 (rom_cs_n_q && ram_cs_n_q))
    else $error("access not seven cycles long");
  byte_order_a: assert property ($fell(we_n_q) && rbs_q |->
    $past(rbs_q) && $past(rbs_q, 2) && $past(we_n_q, 2))
    else $error("high byte write before byte select high");
  addr_hold_a: assert property (state_q == ST_ACCESS
    && $past(state_q) == ST_ACCESS |-> $stable(MEM_ADDR_O))
    else $error("address moved during an access");
endmodule
`default_nettype wire

// >>> sim/srmi_mem_model.sv
// behavioural rom and byte- or word-wide sram on the shared memory bus
`timescale 1ns/1ps
`default_nettype none
module srmi_mem_model (
  input wire logic clk_i,
  input wire srmi_pkg::srmi_addr_t addr_i,
  input wire srmi_pkg::srmi_data_t dev_data_i,
  input wire logic dev_oe_i,
  input wire logic rom_sel_n_i,
  input wire logic ram_sel_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic byte_sel_i,
  input wire logic wide_i,
  output srmi_pkg::srmi_data_t bus_o
);
  import srmi_pkg::*;
  srmi_data_t ram16 [256];
  logic [7:0] ram8 [512];
  srmi_data_t last_q;
  logic [8:0] bidx;
  assign bidx = {addr_i[7:0], byte_sel_i};

  function automatic srmi_data_t rom_word(input srmi_addr_t a);
    return a[15:0] ^ {13'h0, a[18:16]} ^ 16'hc35a;
  endfunction

  // the ram stores what is on the wire, so an undriven bus is caught
  always_ff @(posedge clk_i) begin
    if (!wr_n_i && !ram_sel_n_i && wide_i) begin
      ram16[addr_i[7:0]] <= bus_o;
    end
    if (!wr_n_i && !ram_sel_n_i && !wide_i) begin
      ram8[bidx] <= bus_o[7:0];
    end
    last_q <= bus_o;
  end

  // released lines show the inverse of the last value, never a held copy
  always_comb begin
    bus_o = ~last_q;
    if (dev_oe_i) begin
      bus_o = dev_data_i;
    end else if (!rd_n_i && !rom_sel_n_i) begin
      bus_o = rom_word(addr_i);
    end else if (!rd_n_i && !ram_sel_n_i && wide_i) begin
      bus_o = ram16[addr_i[7:0]];
    end else if (!rd_n_i && !ram_sel_n_i) begin
      bus_o = {~last_q[15:8], ram8[bidx]};
    end
  end
endmodule
`default_nettype wire

// >>> sim/shared_rom_sram_interface_bench.sv
// self-checking bench of the shared rom/ram memory interface
`timescale 1ns/1ps
`default_nettype none
module shared_rom_sram_interface_bench;
  import srmi_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pd_n = 1'b1;
  logic wide = 1'b1;
  logic synth = 1'b1;
  logic [1:0] vld = 2'b00;
  srmi_req_t rq [2];
  logic [1:0] rdy, rsp;
  srmi_data_t rsp_data, dout, din;
  srmi_addr_t addr;
  logic dat_oe, pin_oe, rom_n, ram_n, oe_n, we_n, bsel, run, osc;
  int num_errors = 0;
  int checks = 0;
  int seed = 32'ha846;
  srmi_data_t ref_ram [int];

  always #10 clk = ~clk;

  srmi_top u_srmi_top (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .POWER_DOWN_N_I(pd_n), .RAM_WIDE_I(wide), .SYNTH_RUN_I(synth),
    .DSP_REQ_VALID_I(vld[0]), .DSP_REQ_I(rq[0]),
    .DSP_REQ_READY_O(rdy[0]), .DSP_RSP_VALID_O(rsp[0]),
    .CPU_REQ_VALID_I(vld[1]), .CPU_REQ_I(rq[1]),
    .CPU_REQ_READY_O(rdy[1]), .CPU_RSP_VALID_O(rsp[1]),
    .RSP_DATA_O(rsp_data), .MEM_ADDR_O(addr), .MEM_DATA_I(din),
    .MEM_DATA_O(dout), .MEM_DATA_OE_O(dat_oe), .PIN_OE_O(pin_oe),
    .ROM_SELECT_N_O(rom_n), .RAM_SELECT_N_O(ram_n),
    .MEM_READ_ENABLE_N_O(oe_n), .RAM_WRITE_N_O(we_n),
    .RAM_BYTE_SEL_O(bsel), .RUN_O(run), .OSC_ENABLE_O(osc));

  srmi_mem_model u_srmi_mem_model (.clk_i(clk), .addr_i(addr),
    .dev_data_i(dout), .dev_oe_i(dat_oe), .rom_sel_n_i(rom_n),
    .ram_sel_n_i(ram_n), .rd_n_i(oe_n), .wr_n_i(we_n),
    .byte_sel_i(bsel), .wide_i(wide), .bus_o(din));

  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timed_out(input string nm);
    num_errors++;
    $display("[ERR] %s expected done seen timeout", nm);
    give_verdict();
  endtask

  // pins sampled before the edge updates land
  always @(posedge clk) begin
    if (rst_n && pin_oe) begin
      check("exclusive selects", rom_n | ram_n, 1'b1);
      check("strobe on ram", we_n | (!ram_n & dat_oe), 1'b1);
    end
  end

  task automatic do_reset(input logic w);
    int n;
    @(negedge clk);
    rst_n = 1'b0;
    wide = w;
    vld = 2'b00;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    n = 0;
    @(negedge clk);
    while (rom_n !== 1'b0) begin
      if (++n > 4) timed_out("boot select");
      @(negedge clk);
    end
    check("boot addr", addr, 19'h00100);
    check("run after reset", run, 1'b0);
    while (rsp[1] !== 1'b1) begin
      if (++n > 24) timed_out("boot rsp");
      @(negedge clk);
    end
    check("boot data", rsp_data, u_srmi_mem_model.rom_word(19'h00100));
    ref_ram.delete();
  endtask

  task automatic access(input int p, input logic wr, input logic rm,
      input srmi_addr_t a, input srmi_data_t d);
    int n;
    @(negedge clk);
    rq[p] = '{write: wr, ram: rm, addr: a, wdata: d};
    vld[p] = 1'b1;
    n = 0;
    #1;
    while (rdy[p] !== 1'b1) begin
      if (++n > 40) timed_out("ready");
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    vld[p] = 1'b0;
    for (n = 0; rsp[p] !== 1'b1; n++) begin
      if (n == 1) begin
        check("addr", addr, a);
        check("select", {rom_n, ram_n}, rm ? 2'b10 : 2'b01);
      end
      if (n == 5) check("read enable", oe_n, wr & rm);
      // cnt5 is the one cycle where both byte and word writes pulse
      if (n == 5 && wr && rm) begin
        check("write strobe", we_n, 1'b0);
        check("byte sel", bsel, !wide);
        check("wdata", wide ? dout : dout[7:0], wide ? d : d[15:8]);
      end
      if (n > 20) timed_out("rsp");
      @(negedge clk);
    end
    // rsp rises seven edges after the take, one per memory cycle
    check("latency", n, 7);
    if (!rm) check("rom data", rsp_data, u_srmi_mem_model.rom_word(a));
    if (rm && !wr) check("ram data", rsp_data, ref_ram[a]);
    if (rm && wr) ref_ram[a] = d;
  endtask

  initial begin
    int r;
    logic wr, rm;
    rq[0] = '0;
    rq[1] = '0;
    do_reset(1'b1);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) do_reset(1'b0);
      for (int i = 0; i < 14; i++) begin
        r = $random(seed);
        rm = r[20];
        wr = r[21] | (rm && !ref_ram.exists(r[7:0]));
        access(r[22], wr, rm, rm ? {11'h0, r[7:0]} : r[18:0],
          $random(seed));
      end
      // both processors at once share the bus in turn
      fork
        access(0, 1'b1, 1'b1, 19'h00011, 16'ha55a);
        access(1, 1'b0, 1'b0, 19'h7ffff, 16'h0000);
      join
      access(1, 1'b0, 1'b1, 19'h00011, 16'h0000);
      check("run", run, 1'b1);
      synth = 1'b0;
      repeat (2) @(negedge clk);
      check("run idle", run, 1'b0);
      synth = 1'b1;
    end
    // power-down in mid-access abandons it and floats the pins
    rq[0] = '{write: 1'b0, ram: 1'b0, addr: 19'h00200, wdata: 16'h0};
    vld[0] = 1'b1;
    repeat (4) @(negedge clk);
    pd_n = 1'b0;
    vld[0] = 1'b0;
    @(negedge clk);
    check("pins float", {pin_oe, dat_oe, osc}, 3'h0);
    r = 0;
    repeat (12) begin
      @(negedge clk);
      r = r | rsp;
    end
    // run is registered, so it drops one edge after the pins float
    check("run float", run, 1'b0);
    check("no rsp", r, 0);
    pd_n = 1'b1;
    @(negedge clk);
    check("still floated", pin_oe, 1'b0);
    do_reset(1'b1);
    check("pins back", {pin_oe, osc}, 2'b11);
    access(0, 1'b0, 1'b0, 19'h40123, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
